// [verilog/cfg_pkt_pkg.sv]
package cfg_pkt_pkg;
   // ----------------------------------------
   // header fields
   // ----------------------------------------
   localparam int HDR_TYPE_HI = 31;
   localparam int HDR_TYPE_LO = 29;
   localparam int OPC_HI = 28;
   localparam int OPC_LO = 27;
   localparam int ADDR_HI = 17;
   localparam int ADDR_LO = 13;
   localparam int WC1_HI = 10;
   localparam int WC2_HI = 26;
   localparam logic [2:0] HDR_TYPE1 = 3'h1;
   localparam logic [2:0] HDR_TYPE2 = 3'h2;
   localparam logic [1:0] OPC_NOOP = 2'h0;
   localparam logic [1:0] OPC_READ = 2'h1;
   localparam logic [1:0] OPC_WRITE = 2'h2;
   localparam logic [31:0] SYNC_WORD = 32'hAA995566;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [4:0] REG_CHECKSUM = 5'h00;
   localparam logic [4:0] REG_FRAME_ADDR = 5'h01;
   localparam logic [4:0] REG_FRAME_DATA = 5'h02;
   localparam logic [4:0] REG_COMMAND = 5'h04;
   localparam logic [4:0] REG_CONTROL0 = 5'h05;
   localparam logic [4:0] REG_MASK = 5'h06;
   localparam logic [4:0] REG_CONTROL1 = 5'h18;
   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [4:0] CMD_NULL = 5'h00;
   localparam logic [4:0] CMD_WRITE_CONFIG = 5'h01;
   localparam logic [4:0] CMD_RELEASE_INTERCONNECT = 5'h03;
   localparam logic [4:0] CMD_START = 5'h05;
   localparam logic [4:0] CMD_GLOBAL_RESTORE = 5'h0A;
   localparam logic [4:0] CMD_DROP_ALIGNMENT = 5'h0D;
   // ----------------------------------------
   // reset values and sizes
   // ----------------------------------------
   localparam logic [31:0] REG_RESET = 32'h00000000;
   localparam logic [26:0] COUNT_RESET = 27'h0000000;
   localparam logic [4:0] CMD_RESET = 5'h00;
   localparam int BUF_DEPTH = 2;
   localparam int WORD_W = 32;
endpackage

// [verilog/word_buffer.sv]
`timescale 1ns/1ns
module word_buffer
   import cfg_pkt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fill side
   input wire logic [cfg_pkt_pkg::WORD_W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [cfg_pkt_pkg::WORD_W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [WORD_W-1:0] mem_q [BUF_DEPTH];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] count_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data = mem_q[rd_ptr_q];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (push) wr_ptr_q <= ~wr_ptr_q;
         if (pop) rd_ptr_q <= ~rd_ptr_q;
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wr_ptr_q] <= in_data;
   end
endmodule

// [verilog/config_packet_processor.sv]
// Summary of operation
// R1: header word: type, opcode, address, count
// R2: decode only low five address bits
// R3: type 1 moves word-count data words
// R4: opcode noop, read, write, reserved
// R5: source zeroes reserved header bits
// R6: type 2 only after type 1
// R7: type 2 reuses address, 27-bit count
// R8: type 2 data all to kept address
// R9: steer data words to selected register
// R10: frame data: zero count then type 2
// R11: write-config command enables frame writes
// R12: checksum write compared, mismatch flags error
// R13: restore command pulses global restore
// R14: last-frame command releases interconnect hold
// R15: start command begins startup
// R16: drop alignment, wait for sync word
// R17: mask gates control register writes
// R18: noop headers consumed without access
// R19: five-bit address register map
// R20: command runs on frame address load; the code runs it only when the loaded value differs from the current one
// R21: count down words, then next header
`timescale 1ns/1ns
module config_packet_processor
   import cfg_pkt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // configuration word stream
   input wire logic [cfg_pkt_pkg::WORD_W-1:0] cfg_word,
   input wire logic cfg_valid,
   output logic cfg_ready,
   // frame data out
   output logic [cfg_pkt_pkg::WORD_W-1:0] frame_data,
   output logic frame_data_valid,
   input wire logic frame_data_ready,
   // computed checksum from outside
   input wire logic [31:0] computed_crc,
   // read-back path
   output logic [4:0] read_addr,
   output logic read_strobe,
   // status and control
   output logic word_aligned_flag,
   output logic write_config_cmd,
   output logic crc_error,
   output logic global_restore_cmd,
   output logic release_interconnect_cmd,
   output logic interconnect_hold_n,
   output logic startup_start,
   output logic drop_alignment_cmd,
   output logic sequence_error,
   output logic [31:0] frame_address,
   output logic [31:0] control0,
   output logic [31:0] control1,
   output logic [31:0] mask_value,
   output logic [4:0] command_value
);
   import cfg_pkt_pkg::*;

   typedef enum logic [1:0] {ST_HUNT, ST_HEADER, ST_DATA} state_e;

   state_e state_q;
   logic [26:0] count_q;
   logic [4:0] addr_q;
   logic [1:0] opc_q;
   logic last_type1_q;
   logic [31:0] far_q, control_reg_0_q, control_reg_1_q, mask_q;
   logic [4:0] cmd_q;
   logic write_config_cmd_q, crc_err_q, hold_n_q, seq_err_q;
   logic restore_q, release_q, start_q, drop_alignment_cmd_q;
   logic [4:0] rd_addr_q;
   logic rd_q;

   // ----------------------------------------
   // word acceptance and decode
   // ----------------------------------------
   logic fb_in_ready;
   wire take = cfg_valid && cfg_ready;
   // R1: header field split
   wire [2:0] hdr_type = cfg_word[HDR_TYPE_HI:HDR_TYPE_LO];
   wire [1:0] hdr_opc = cfg_word[OPC_HI:OPC_LO];
   // R2: low five address bits only
   wire [4:0] hdr_addr = cfg_word[ADDR_HI:ADDR_LO];
   wire [26:0] hdr_wc1 = {16'h0000, cfg_word[WC1_HI:0]};
   // R7: type 2 count bits
   wire [26:0] hdr_wc2 = cfg_word[WC2_HI:0];
   wire is_hdr = take && (state_q == ST_HEADER);
   wire is_t1 = is_hdr && (hdr_type == HDR_TYPE1);
   wire is_t2 = is_hdr && (hdr_type == HDR_TYPE2);
   wire is_data = take && (state_q == ST_DATA);
   // R4: write and read opcodes
   wire wr_data = is_data && (opc_q == OPC_WRITE);
   wire rd_data = is_data && (opc_q == OPC_READ);
   // R9 R19: register steering
   wire wr_far = wr_data && (addr_q == REG_FRAME_ADDR);
   wire wr_frame_data_in_reg = wr_data && (addr_q == REG_FRAME_DATA);
   wire wr_cmd = wr_data && (addr_q == REG_COMMAND);
   wire wr_crc = wr_data && (addr_q == REG_CHECKSUM);
   wire wr_control_reg_0 = wr_data && (addr_q == REG_CONTROL0);
   wire wr_control_reg_1 = wr_data && (addr_q == REG_CONTROL1);
   wire wr_mask = wr_data && (addr_q == REG_MASK);
   // R11: frame data needs write enable
   wire frame_data_in_reg_push = wr_frame_data_in_reg && write_config_cmd_q;
   // frame data stalls the stream when buffer full
   assign cfg_ready = (state_q != ST_DATA) || !(opc_q == OPC_WRITE)
      || (addr_q != REG_FRAME_DATA) || fb_in_ready || !write_config_cmd_q;
   // R20: command runs on a frame address load whose value differs from far_q
   wire run_cmd = wr_far && (cfg_word != far_q);
   wire [4:0] new_cmd = cfg_word[4:0];
   // R17: masked control update
   wire [31:0] control_reg_0_d = (control_reg_0_q & ~mask_q) | (cfg_word & mask_q);
   wire [31:0] control_reg_1_d = (control_reg_1_q & ~mask_q) | (cfg_word & mask_q);
   wire [26:0] count_dec = count_q - 27'h0000001;
   wire data_last = is_data && (count_q == 27'h0000001);

   // ----------------------------------------
   // packet state machine
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_HUNT;
         count_q <= COUNT_RESET;
         addr_q <= CMD_RESET;
         opc_q <= OPC_NOOP;
         last_type1_q <= 1'b0;
         seq_err_q <= 1'b0;
      end else if (take) begin
         case (state_q)
            ST_HUNT: begin
               if (cfg_word == SYNC_WORD) state_q <= ST_HEADER;
            end
            ST_HEADER: begin
               if (is_t1) begin
                  addr_q <= hdr_addr;
                  opc_q <= hdr_opc;
                  count_q <= hdr_wc1;
                  last_type1_q <= 1'b1;
                  // R18: noop header consumed
                  // R3: type 1 data phase
                  if (hdr_opc != OPC_NOOP && hdr_wc1 != COUNT_RESET) state_q <= ST_DATA;
               end else if (is_t2) begin
                  // R6: type 2 needs prior type 1
                  if (!last_type1_q) begin
                     seq_err_q <= 1'b1;
                  end else begin
                     // R8: keep address, new count
                     count_q <= hdr_wc2;
                     if (hdr_wc2 != COUNT_RESET) state_q <= ST_DATA;
                  end
               end else begin
                  seq_err_q <= 1'b1;
               end
            end
            ST_DATA: begin
               // R21: count down remaining words
               count_q <= count_dec;
               if (data_last) state_q <= ST_HEADER;
               // R16: drop alignment wins
               if (wr_cmd && new_cmd == CMD_DROP_ALIGNMENT) state_q <= ST_HUNT;
               if (run_cmd && cmd_q == CMD_DROP_ALIGNMENT) state_q <= ST_HUNT;
            end
            default: state_q <= ST_HUNT;
         endcase
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   wire [4:0] exec_code = wr_cmd ? new_cmd : cmd_q;
   wire exec = wr_cmd || run_cmd;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         far_q <= REG_RESET;
         control_reg_0_q <= REG_RESET;
         control_reg_1_q <= REG_RESET;
         mask_q <= REG_RESET;
         cmd_q <= CMD_RESET;
         write_config_cmd_q <= 1'b0;
         crc_err_q <= 1'b0;
         hold_n_q <= 1'b0;
      end else begin
         if (wr_far) far_q <= cfg_word;
         if (wr_cmd) cmd_q <= new_cmd;
         if (wr_mask) mask_q <= cfg_word;
         if (wr_control_reg_0) control_reg_0_q <= control_reg_0_d;
         if (wr_control_reg_1) control_reg_1_q <= control_reg_1_d;
         // R12: checksum compare
         if (wr_crc) crc_err_q <= (cfg_word != computed_crc);
         // R11: write enable latch
         if (exec && exec_code == CMD_WRITE_CONFIG) write_config_cmd_q <= 1'b1;
         // R14: release interconnect hold
         if (exec && exec_code == CMD_RELEASE_INTERCONNECT) hold_n_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // command pulses
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         restore_q <= 1'b0;
         release_q <= 1'b0;
         start_q <= 1'b0;
         drop_alignment_cmd_q <= 1'b0;
         rd_q <= 1'b0;
         rd_addr_q <= CMD_RESET;
      end else begin
         // R13: restore pulse
         restore_q <= exec && exec_code == CMD_GLOBAL_RESTORE;
         release_q <= exec && exec_code == CMD_RELEASE_INTERCONNECT;
         // R15: startup pulse
         start_q <= exec && exec_code == CMD_START;
         drop_alignment_cmd_q <= exec && exec_code == CMD_DROP_ALIGNMENT;
         rd_q <= rd_data;
         if (rd_data) rd_addr_q <= addr_q;
      end
   end

   // ----------------------------------------
   // frame data buffer
   // ----------------------------------------
   // R10: frame data words to buffer
   word_buffer u_buf (
      .clk(clk),
      .reset(reset),
      .in_data(cfg_word),
      .in_valid(frame_data_in_reg_push),
      .in_ready(fb_in_ready),
      .out_data(frame_data),
      .out_valid(frame_data_valid),
      .out_ready(frame_data_ready)
   );

   assign word_aligned_flag = (state_q != ST_HUNT);
   assign write_config_cmd = write_config_cmd_q;
   assign crc_error = crc_err_q;
   assign global_restore_cmd = restore_q;
   assign release_interconnect_cmd = release_q;
   assign interconnect_hold_n = hold_n_q;
   assign startup_start = start_q;
   assign drop_alignment_cmd = drop_alignment_cmd_q;
   assign sequence_error = seq_err_q;
   assign frame_address = far_q;
   assign control0 = control_reg_0_q;
   assign control1 = control_reg_1_q;
   assign mask_value = mask_q;
   assign command_value = cmd_q;
   assign read_addr = rd_addr_q;
   assign read_strobe = rd_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_restore;
      @(posedge clk) disable iff (reset)
      (wr_cmd && new_cmd == CMD_GLOBAL_RESTORE) |=> global_restore_cmd ##1 !global_restore_cmd;
   endproperty
   a_restore: assert property (p_restore) else $error("restore pulse wrong"); // R13

   property p_release;
      @(posedge clk) disable iff (reset)
      (wr_cmd && new_cmd == CMD_RELEASE_INTERCONNECT) |=> interconnect_hold_n;
   endproperty
   a_release: assert property (p_release) else $error("hold not released"); // R14

   property p_start;
      @(posedge clk) disable iff (reset)
      (wr_cmd && new_cmd == CMD_START) |=> startup_start;
   endproperty
   a_start: assert property (p_start) else $error("startup not begun"); // R15

   property p_drop_alignment_cmd;
      @(posedge clk) disable iff (reset)
      (wr_cmd && new_cmd == CMD_DROP_ALIGNMENT) |=> !word_aligned_flag;
   endproperty
   a_drop_alignment_cmd: assert property (p_drop_alignment_cmd) else $error("alignment kept"); // R16

   property p_crc;
      @(posedge clk) disable iff (reset)
      wr_crc |=> (crc_error == ($past(cfg_word) != $past(computed_crc)));
   endproperty
   a_crc: assert property (p_crc) else $error("checksum flag wrong"); // R12

   property p_mask;
      @(posedge clk) disable iff (reset)
      wr_control_reg_0 |=> ((control0 & ~$past(mask_q)) == ($past(control_reg_0_q) & ~$past(mask_q)));
   endproperty
   a_mask: assert property (p_mask) else $error("masked bits changed"); // R17

   property p_noop;
      @(posedge clk) disable iff (reset)
      (is_t1 && hdr_opc == OPC_NOOP) |=> (state_q == ST_HEADER);
   endproperty
   a_noop: assert property (p_noop) else $error("noop opened data"); // R18

   property p_count;
      @(posedge clk) disable iff (reset)
      (is_data && count_q > 27'h0000001 && !wr_cmd && !run_cmd) |=>
         (count_q == $past(count_q) - 27'h0000001) && state_q == ST_DATA;
   endproperty
   a_count: assert property (p_count) else $error("count wrong"); // R21

   property p_write_config_cmd;
      @(posedge clk) disable iff (reset)
      frame_data_valid |-> write_config_cmd;
   endproperty
   a_write_config_cmd: assert property (p_write_config_cmd) else $error("frame data without enable"); // R11
endmodule

// [bench/cfg_word_source.sv]
`timescale 1ns/1ns
// ----------------------------------------
// configuration word source
// ----------------------------------------
module cfg_word_source (
   // clock
   input wire logic clk,
   // word stream
   output logic [31:0] cfg_word,
   output logic cfg_valid,
   input wire logic cfg_ready
);
   int gap = 0;
   initial begin
      cfg_word = 32'h00000000;
      cfg_valid = 1'b0;
   end
   task automatic send(input logic [31:0] w);
      repeat (gap) idle();
      @(negedge clk);
      cfg_word = w;
      cfg_valid = 1'b1;
      // a stall that never ends is caught by the bench ceiling
      do begin
         @(posedge clk);
      end while (cfg_ready !== 1'b1);
   endtask
   // idle bus shows inverse of last word
   task automatic idle();
      @(negedge clk);
      cfg_valid = 1'b0;
      cfg_word = ~cfg_word;
   endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   import cfg_pkt_pkg::*;
   typedef struct {logic [13:0] a; logic [31:0] d; int s; logic [31:0] e;} row_s;
   localparam logic [31:0] NOOP = 32'h20000000;
   logic clk, reset, cfg_valid, cfg_ready, frame_data_valid, frame_data_ready, read_strobe;
   logic [31:0] cfg_word, frame_data, computed_crc, frame_address, control0, control1;
   logic [31:0] mask_value;
   logic [4:0] read_addr, command_value, rd_addr;
   logic word_aligned_flag, write_config_cmd, crc_error, global_restore_cmd, startup_start;
   logic release_interconnect_cmd, interconnect_hold_n, drop_alignment_cmd, sequence_error;
   logic saw_full;
   int fails = 0, n_tests = 0, cycles = 0, n_restore, n_start, n_drop, n_read;
   int n_rel = 0;
   logic [31:0] got_q[$];
   row_s rows[13];
   cfg_word_source src (.clk(clk), .cfg_word(cfg_word), .cfg_valid(cfg_valid),
      .cfg_ready(cfg_ready));
   config_packet_processor dut (.clk(clk), .reset(reset), .cfg_word(cfg_word),
      .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .frame_data(frame_data),
      .frame_data_valid(frame_data_valid), .frame_data_ready(frame_data_ready),
      .computed_crc(computed_crc), .read_addr(read_addr), .read_strobe(read_strobe),
      .word_aligned_flag(word_aligned_flag), .write_config_cmd(write_config_cmd),
      .crc_error(crc_error), .global_restore_cmd(global_restore_cmd),
      .release_interconnect_cmd(release_interconnect_cmd),
      .interconnect_hold_n(interconnect_hold_n), .startup_start(startup_start),
      .drop_alignment_cmd(drop_alignment_cmd), .sequence_error(sequence_error),
      .frame_address(frame_address), .control0(control0), .control1(control1),
      .mask_value(mask_value), .command_value(command_value));
   // ----------------------------------------
   // clock and monitors
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (global_restore_cmd === 1'b1) n_restore++;
      if (release_interconnect_cmd === 1'b1) n_rel++;
      if (startup_start === 1'b1) n_start++;
      if (drop_alignment_cmd === 1'b1) n_drop++;
      if (read_strobe === 1'b1) begin
         n_read++;
         rd_addr = read_addr;
      end
      if (frame_data_valid === 1'b1 && frame_data_ready === 1'b1) got_q.push_back(frame_data);
      if (cfg_valid === 1'b1 && cfg_ready === 1'b0) saw_full = 1'b1;
      if (cycles > 6000) begin
         fails++;
         $display("ERROR %0t run too long", $time);
         test_done();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] obs(input int s);
      case (s)
         0: return mask_value;
         1: return control0;
         2: return control1;
         3: return frame_address;
         4: return 32'(n_restore);
         5: return 32'(n_start);
         6: return {31'h0, interconnect_hold_n};
         7: return {31'h0, write_config_cmd};
         default: return {31'h0, crc_error};
      endcase
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      src.send({HDR_TYPE1, OPC_WRITE, a, 2'h0, 11'h001});
      src.send(d);
      src.send(NOOP);
      src.idle();
      repeat (2) @(negedge clk);
   endtask
   task automatic clr();
      n_restore = 0;
      n_start = 0;
      n_drop = 0;
      n_read = 0;
   endtask
   task automatic do_reset();
      reset = 1'b1;
      repeat (4) @(negedge clk);
      reset = 1'b0;
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      frame_data_ready = 1'b1;
      computed_crc = 32'hC81874CB;
      saw_full = 1'b0;
      clr();
      rows = '{'{14'h0006, 32'hFFFFFFFF, 0, 32'hFFFFFFFF}, '{14'h0025, 32'h12345678, 1,
         32'h12345678}, '{14'h0018, 32'h0000ABCD, 2, 32'h0000ABCD}, '{14'h0006, 32'h00000100,
         0, 32'h00000100}, '{14'h0005, 32'h00000501, 1, 32'h12345778}, '{14'h0001,
         32'h03BE0000, 3, 32'h03BE0000}, '{14'h0004, 32'h0000000A, 4, 32'h1}, '{14'h0001,
         32'h00000020, 4, 32'h1}, '{14'h0004, 32'h00000005, 5, 32'h1}, '{14'h0004,
         32'h00000003, 6, 32'h1}, '{14'h0004, 32'h00000001, 7, 32'h1}, '{14'h0000,
         32'hE3AD7EA5, 8, 32'h1}, '{14'h0000, 32'hC81874CB, 8, 32'h0}};
      do_reset();
      @(negedge clk);
      check(interconnect_hold_n, 32'h0);
      check(word_aligned_flag, 32'h0);
      wr(14'h0006, 32'hFFFFFFFF);
      check(mask_value, 32'h0);
      src.send(SYNC_WORD);
      src.idle();
      @(negedge clk);
      check(word_aligned_flag, 32'h1);
      note("reset and sync");
      foreach (rows[i]) begin
         clr();
         src.gap = i % 2;
         wr(rows[i].a, rows[i].d);
         check(obs(rows[i].s), rows[i].e);
      end
      src.gap = 0;
      check(32'(n_rel), 32'h1);
      check(command_value, CMD_WRITE_CONFIG);
      note("register rows");
      frame_data_ready = 1'b0;
      got_q.delete();
      fork
         begin
            src.send(32'h30004000);
            src.send(32'h50000003);
            for (int i = 1; i < 4; i++) src.send(32'h11111111 * i);
            src.send(NOOP);
            src.idle();
         end
         begin
            repeat (12) @(negedge clk);
            frame_data_ready = 1'b1;
         end
      join
      repeat (3) @(negedge clk);
      check(saw_full, 32'h1);
      check(32'(got_q.size()), 32'h3);
      for (int i = 0; i < 3; i++) check(got_q[i], 32'h11111111 * (i + 1));
      wr(14'h0006, 32'h0000F00F);
      check(mask_value, 32'h0000F00F);
      note("frame data");
      clr();
      src.send({HDR_TYPE1, OPC_READ, 14'h0005, 2'h0, 11'h001});
      src.send(NOOP);
      src.send(NOOP);
      src.idle();
      repeat (2) @(negedge clk);
      check(32'(n_read), 32'h1);
      check(rd_addr, REG_CONTROL0);
      src.send({HDR_TYPE1, 2'h3, 14'h0006, 2'h0, 11'h001});
      src.send(32'hFFFFFFFF);
      src.send(NOOP);
      src.idle();
      repeat (2) @(negedge clk);
      check(mask_value, 32'h0000F00F);
      check(sequence_error, 32'h0);
      note("read and reserved");
      wr(14'h0004, 32'h0000000D);
      check(32'(n_drop), 32'h1);
      check(word_aligned_flag, 32'h0);
      wr(14'h0006, 32'h00000000);
      check(mask_value, 32'h0000F00F);
      note("drop alignment");
      do_reset();
      src.send(SYNC_WORD);
      src.send(32'h50000001);
      src.send(NOOP);
      src.idle();
      repeat (2) @(negedge clk);
      check(sequence_error, 32'h1);
      check(interconnect_hold_n, 32'h0);
      got_q.delete();
      src.send(32'h30004001);
      src.send(32'h5A5A5A5A);
      src.send(NOOP);
      src.idle();
      repeat (3) @(negedge clk);
      check(32'(got_q.size()), 32'h0);
      check(write_config_cmd, 32'h0);
      note("type 2 alone");
      test_done();
   end
endmodule
